// >>> src/tro_pkg.sv
// Purpose: Shared constants, types and helpers of the temperature readout
// Assumes: 16-bit register words, three sensors, 50 MHz device clock
// Notes:   Capabilities word is built from fields and checked against reset
package tro_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [5:0]  ADDR_TEMP_CAPS   = 6'h08;
  localparam logic [5:0]  ADDR_TEMP_RESULT = 6'h09;
  localparam logic [15:0] RD_ZERO          = 16'h0000;

  // ----------------------------------------------------------------------
  // Capabilities fields
  // ----------------------------------------------------------------------
  localparam int          CAP_RES_LSB    = 0;
  localparam logic [2:0]  CAP_RES_HALF_C = 3'h1;
  localparam int          CAP_NBITS_LSB  = 3;
  localparam logic [2:0]  CAP_NBITS_10   = 3'h1;
  localparam int          CAP_SIGN_BIT   = 6;
  localparam int          CAP_ROUT_BIT   = 7;
  localparam int          CAP_LOCAL_BIT  = 8;
  localparam int          CAP_REMOTE_LSB = 9;
  localparam logic [2:0]  CAP_REMOTES    = 3'h2;
  localparam logic [15:0] CAP_RESET      = 16'h0549;

  // ----------------------------------------------------------------------
  // Result word fields
  // ----------------------------------------------------------------------
  localparam int          RES_TEMP_LSB    = 6;
  localparam int          RES_SENSOR_LSB  = 2;
  localparam int          RES_ERR_BIT     = 1;
  localparam logic [9:0]  TEMP_FAULT_CODE = 10'h200;
  localparam logic [1:0]  LOCAL_SENSOR    = 2'h0;
  localparam logic [1:0]  LAST_SENSOR     = 2'h2;
  localparam int          NUM_SENSORS     = 3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ         = 50;
  localparam int CONV_TIMEOUT_US = 100;
  localparam int CONV_TIMEOUT_CYC = CONV_TIMEOUT_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
  } tro_reg_req_t;

  typedef struct packed {
    logic [9:0] temp;
    logic       fault;
  } tro_conv_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT
  } tro_scan_t;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] caps_word();
    logic [15:0] w;
    w = 16'h0000;
    w[CAP_RES_LSB +: 3]    = CAP_RES_HALF_C;
    w[CAP_NBITS_LSB +: 3]  = CAP_NBITS_10;
    w[CAP_SIGN_BIT]        = 1'b1;
    w[CAP_ROUT_BIT]        = 1'b0;
    w[CAP_LOCAL_BIT]       = 1'b1;
    w[CAP_REMOTE_LSB +: 3] = CAP_REMOTES;
    return w;
  endfunction

  // Returns {found, index} of the next enabled sensor after cur
  function automatic logic [2:0] next_enabled(input logic [1:0] cur,
                                              input logic [2:0] en);
    logic [1:0] idx;
    logic [2:0] r;
    r   = 3'h0;
    idx = cur;
    for (int k = 0; k < NUM_SENSORS; k++) begin
      idx = (idx == LAST_SENSOR) ? LOCAL_SENSOR : idx + 2'h1;
      if (!r[2] && en[idx]) begin
        r = {1'b1, idx};
      end
    end
    return r;
  endfunction

endpackage

// >>> src/tro_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin level
// Assumes: Input is asynchronous to mclk_i
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module tro_sync
  import tro_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Level
  input  wire logic async_i,
  output logic      sync_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sync_o <= 1'b0;
    end else if (s2_r == s3_r) begin
      sync_o <= s3_r;
    end
  end

endmodule
`default_nettype wire

// >>> src/tro_fmt.sv
// Purpose: Packs a conversion into the 16-bit temperature result word
// Assumes: Sensor index 0 is the local sensor
// Notes:   Purely combinational; the caller registers the word
`timescale 1ns/10ps
`default_nettype none
module tro_fmt
  import tro_pkg::*;
(
  // Conversion
  input  wire logic [9:0]  temp_i,
  input  wire logic [1:0]  sensor_index_i,
  input  wire logic        fault_i,
  // Word
  output logic      [15:0] word_o
);

  logic remote_err;

  // Local results never carry the error flag
  assign remote_err = fault_i && (sensor_index_i != LOCAL_SENSOR);

  always_comb begin
    word_o = 16'h0000;
    word_o[RES_TEMP_LSB +: 10] = remote_err ? TEMP_FAULT_CODE : temp_i;
    word_o[RES_SENSOR_LSB +: 2] = sensor_index_i;
    word_o[RES_ERR_BIT] = remote_err;
  end

endmodule
`default_nettype wire

// >>> src/tro_top.sv
// Purpose: Temperature readout registers, scan sequencer and status flags
// Assumes: Register requests arrive from bus logic on mclk_i
// Notes:   Both registers are read-only; writes are accepted and dropped
//
// Summary of operation
// - Capabilities register reads the constant 0549h for all sensors.
// - Capabilities bits 2..0 read 001: half degree per LSB.
// - Capabilities bits 5..3 read 001: ten significant bits.
// - Capabilities bit 6 reads one: signed two's complement data.
// - Capabilities bit 7 reads zero: sixteen-bit readout register.
// - Capabilities bit 8 reads one: local sensor present.
// - Capabilities bits 11..9 read two remote sensors.
// - Reserved bits of both registers read zero.
// - Result bits 3..2 give the sensor index, zero is local.
// - Error bit reads zero for local sensor results.
// - A remote diode fault forces temperature code 200h.
// - Storing a result sets pending, held until the result is read.
// - Reading the result clears overrun, and clears pending unless a result is stored that cycle.
// - A result arriving before the read overwrites and sets overrun.
// - Enabled sensors are scanned round-robin ascending, disabled skipped.
`timescale 1ns/10ps
`default_nettype none
module tro_top
  import tro_pkg::*;
#(
  parameter int CONV_TIMEOUT_CYCLES = CONV_TIMEOUT_CYC
)(
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          nrst_i,
  // Register access
  input  wire tro_reg_req_t  reg_req_i,
  output logic        [15:0] rdata_o,
  output logic               rvalid_o,
  // Scan control
  input  wire logic   [2:0]  sensor_en_i,
  // Converter handshake
  output logic               conv_start_o,
  output logic        [1:0]  conv_sensor_o,
  input  wire logic          conv_done_i,
  input  wire tro_conv_t     conv_i,
  // Remote diode fault pins, one per remote
  input  wire logic   [1:0]  diode_fault_pin_i,
  // Status
  output logic               temp_result_pending_o,
  output logic               temp_overrun_flag_o,
  output logic               func_event_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam int TMR_W = $clog2(CONV_TIMEOUT_CYCLES + 1);

  if (CONV_TIMEOUT_CYCLES < 1) begin : g_bad_timeout
    $error("CONV_TIMEOUT_CYCLES must be at least one");
  end
  if (caps_word() != CAP_RESET) begin : g_bad_caps
    $error("Capabilities fields disagree with reset word");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  tro_scan_t          state_r;
  logic [1:0]         cur_r;
  logic [TMR_W-1:0]   tmr_r;
  logic [15:0]        result_r;
  logic [1:0]         pin_fault;
  logic [2:0]         next_sel;
  logic               timeout;
  logic               finish;
  logic               new_valid;
  logic               fault_now;
  logic               rd_result;
  logic [15:0]        fmt_word;

  // ----------------------------------------------------------------------
  // Fault pin synchronisers
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_sync
    tro_sync u_sync (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .async_i (diode_fault_pin_i[g]),
      .sync_o  (pin_fault[g])
    );
  end

  // ----------------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------------
  assign next_sel = next_enabled(cur_r, sensor_en_i);
  assign timeout  = (tmr_r == TMR_W'(CONV_TIMEOUT_CYCLES));
  assign finish   = (state_r == ST_WAIT) && (conv_done_i || timeout);
  // A sensor disabled mid-conversion yields no result
  assign new_valid = finish && sensor_en_i[cur_r];

  // Reset index at the last sensor so the first scan starts at zero
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_r      <= ST_IDLE;
      cur_r        <= LAST_SENSOR;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (next_sel[2]) begin
            cur_r        <= next_sel[1:0];
            conv_start_o <= 1'b1;
            state_r      <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (finish || !sensor_en_i[cur_r]) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign conv_sensor_o = cur_r;

  // Timeout guards against a converter that never answers
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      tmr_r <= '0;
    end else if (state_r != ST_WAIT) begin
      tmr_r <= '0;
    end else if (!timeout) begin
      tmr_r <= tmr_r + TMR_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------------
  always_comb begin
    fault_now = timeout || conv_i.fault;
    if (cur_r == 2'h1) begin
      fault_now = fault_now || pin_fault[0];
    end else if (cur_r == 2'h2) begin
      fault_now = fault_now || pin_fault[1];
    end
  end

  tro_fmt u_fmt (
    .temp_i         (conv_i.temp),
    .sensor_index_i (cur_r),
    .fault_i        (fault_now),
    .word_o         (fmt_word)
  );

  // Newer result always overwrites; no buffering of older ones
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      result_r <= 16'h0000;
    end else if (new_valid) begin
      result_r <= fmt_word;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      func_event_o <= 1'b0;
    end else begin
      func_event_o <= new_valid;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  assign rd_result = reg_req_i.rd && (reg_req_i.addr == ADDR_TEMP_RESULT);

  // Set wins over the clearing read
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      temp_result_pending_o <= 1'b0;
    end else if (new_valid) begin
      temp_result_pending_o <= 1'b1;
    end else if (rd_result) begin
      temp_result_pending_o <= 1'b0;
    end
  end

  // A read in the same cycle consumes the old result, so no overrun
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      temp_overrun_flag_o <= 1'b0;
    end else if (new_valid && temp_result_pending_o && !rd_result) begin
      temp_overrun_flag_o <= 1'b1;
    end else if (rd_result) begin
      temp_overrun_flag_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  // Writes are never decoded: both registers are read-only
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rdata_o  <= RD_ZERO;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= reg_req_i.rd;
      if (!reg_req_i.rd) begin
        rdata_o <= rdata_o;
      end else if (reg_req_i.addr == ADDR_TEMP_CAPS) begin
        rdata_o <= caps_word();
      end else if (reg_req_i.addr == ADDR_TEMP_RESULT) begin
        rdata_o <= result_r;
      end else begin
        rdata_o <= RD_ZERO;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/tro_top_properties.sv
// Purpose: Port-level properties of the temperature readout block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound onto tro_top below the module
`timescale 1ns/10ps
`default_nettype none
module tro_top_properties
  import tro_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire tro_reg_req_t reg_req_i,
  input  wire logic [15:0]  rdata_o,
  input  wire logic         rvalid_o,
  input  wire logic         conv_start_o,
  input  wire logic         temp_result_pending_o,
  input  wire logic         temp_overrun_flag_o,
  input  wire logic         func_event_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic rd_res;
  logic rd_cap;
  assign rd_res = reg_req_i.rd && reg_req_i.addr == ADDR_TEMP_RESULT;
  assign rd_cap = reg_req_i.rd && reg_req_i.addr == ADDR_TEMP_CAPS;
  AST_CAPS: assert property (rd_cap |=> rvalid_o && rdata_o == 16'h0549)
    else $error("capabilities word wrong");
  AST_RSV: assert property (rd_res |=> rdata_o[5:4] == 2'h0 && !rdata_o[0])
    else $error("reserved result bits set");
  AST_SENSOR_INDEX: assert property (rd_res |=> rvalid_o && rdata_o[3:2] != 2'h3)
    else $error("sensor index out of range");
  AST_LOC: assert property (rd_res ##1 rdata_o[3:2] == 2'h0 |-> !rdata_o[1])
    else $error("error bit on local result");
  AST_FLT: assert property (rd_res ##1 rdata_o[1] |-> rdata_o[15:6] == 10'h200)
    else $error("faulted result not forced");
  AST_PEND: assert property (func_event_o |-> temp_result_pending_o)
    else $error("pending not set on store");
  AST_CLR: assert property (rd_res |=> !temp_overrun_flag_o && (func_event_o || !temp_result_pending_o))
    else $error("flags not cleared by read");
  AST_OVR: assert property (func_event_o && $past(temp_result_pending_o) && !$past(rd_res) |-> temp_overrun_flag_o)
    else $error("overrun not set");
  AST_GAP: assert property (conv_start_o |=> !conv_start_o)
    else $error("starts back to back");
  AST_HOLD: assert property (!reg_req_i.rd |=> $stable(rdata_o))
    else $error("read data moved without read");
  cover property (func_event_o && temp_overrun_flag_o);
  cover property (rd_res ##1 rdata_o[1]);
  cover property (rd_cap);
  cover property (conv_start_o ##2 temp_result_pending_o);
endmodule
bind tro_top tro_top_properties u_tro_top_properties (
  .mclk_i, .nrst_i, .reg_req_i, .rdata_o, .rvalid_o, .conv_start_o,
  .temp_result_pending_o, .temp_overrun_flag_o, .func_event_o);
`default_nettype wire

// >>> verif/tro_conv_model.sv
// Purpose: Converter stand-in answering conversion starts
// Assumes: One conversion at a time
// Notes:   Data toggles when not valid; mute starves to force timeout
`timescale 1ns/10ps
`default_nettype none
module tro_conv_model
  import tro_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       start_i,
  input  wire logic [7:0] delay_i,
  input  wire logic       mute_i,
  input  wire tro_conv_t  val_i,
  output logic            done_o,
  output tro_conv_t       conv_o
);
  logic [7:0] cnt_r;
  logic       busy_r;
  always_ff @(posedge mclk_i) begin
    done_o <= 1'b0;
    conv_o <= ~conv_o;
    if (!nrst_i) begin
      busy_r <= 1'b0;
      conv_o <= '0;
    end else if (start_i && !mute_i) begin
      busy_r <= 1'b1;
      cnt_r  <= delay_i;
    end else if (busy_r && cnt_r == 8'h0) begin
      busy_r <= 1'b0;
      done_o <= 1'b1;
      conv_o <= val_i;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tro_top_tb.sv
// Purpose: Self-checking bench for the temperature readout block
// Assumes: Converter model answers 5 to 12 cycles after taking a start
// Notes:   First result after an enable change is only drained
`timescale 1ns/10ps
`default_nettype none
module tro_top_tb
  import tro_pkg::*;
;
  logic         mclk_i, nrst_i, rvalid, start, done, pend, ovr, evt, mute;
  tro_reg_req_t req;
  logic [15:0]  rdata;
  logic [1:0]   sens, pins, prev;
  logic [2:0]   en;
  logic [7:0]   dly;
  tro_conv_t    val, conv;
  int           fail_count, n_tests;
  tro_top #(.CONV_TIMEOUT_CYCLES(20)) u_tro_top (
    .mclk_i, .nrst_i, .reg_req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .sensor_en_i(en), .conv_start_o(start), .conv_sensor_o(sens),
    .conv_done_i(done), .conv_i(conv), .diode_fault_pin_i(pins),
    .temp_result_pending_o(pend), .temp_overrun_flag_o(ovr),
    .func_event_o(evt));
  tro_conv_model u_tro_conv_model (.mclk_i, .nrst_i, .start_i(start),
    .delay_i(dly), .mute_i(mute), .val_i(val), .done_o(done), .conv_o(conv));
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  function automatic logic [15:0] exp_word(logic [1:0] s, tro_conv_t v,
                                           logic [1:0] p);
    logic e;
    e = (s != 2'h0) && (v.fault || p[s - 2'h1]);
    return {e ? 10'h200 : v.temp, 2'h0, s, e, 1'b0};
  endfunction
  function automatic logic [1:0] exp_next(logic [1:0] c, logic [2:0] m);
    logic [1:0] i;
    i = c;
    repeat (3) begin
      i = (i == 2'h2) ? 2'h0 : i + 2'h1;
      if (m[i]) return i;
    end
    return c;
  endfunction
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a};
    @(posedge mclk_i);
    req <= '0;
    #1;
    chk("rvalid", 16'h1, {15'h0, rvalid});
    d = rdata;
  endtask
  task automatic wr(input logic [5:0] a);
    @(posedge mclk_i);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a};
    @(posedge mclk_i);
    req <= '0;
  endtask
  task automatic wait_evt();
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      #1;
      k++;
    end while (!evt && k < 200);
    if (evt !== 1'b1) begin
      chk("event wait", 16'h1, 16'h0);
      tally_and_finish();
    end
  endtask
  initial begin
    logic [15:0] d;
    tro_conv_t   v;
    logic [1:0]  s;
    fail_count = 0;
    n_tests = 0;
    req = '0;
    en = 3'h0;
    pins = 2'h0;
    dly = 8'h4;
    mute = 1'b0;
    val = '0;
    nrst_i = 1'b0;
    void'($urandom(32'h3C7B));
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(ADDR_TEMP_CAPS, d);
    chk("caps", 16'h0549, d);
    wr(ADDR_TEMP_CAPS);
    wr(ADDR_TEMP_RESULT);
    rd(ADDR_TEMP_CAPS, d);
    chk("caps after write", 16'h0549, d);
    rd(ADDR_TEMP_RESULT, d);
    chk("result after write", 16'h0000, d);
    rd(6'h3F, d);
    chk("unmapped", 16'h0000, d);
    // Every nonzero enable pattern, random data, fault pins and latency
    for (int g = 1; g < 8; g++) begin
      @(posedge mclk_i);
      en <= g[2:0];
      pins <= 2'($urandom);
      for (int i = 0; i < 5; i++) begin
        @(posedge mclk_i);
        val <= tro_conv_t'(11'($urandom));
        dly <= 8'($urandom_range(11, 4));
        wait_evt();
        s = sens;
        v = val;
        rd(ADDR_TEMP_RESULT, d);
        if (i > 0) begin
          chk("sensor order", {14'h0, exp_next(prev, en)}, {14'h0, s});
          chk("result word", exp_word(s, v, pins), d);
        end
        prev = s;
      end
    end
    @(posedge mclk_i);
    en <= 3'h7;
    wait_evt();
    wait_evt();
    chk("overrun flags", 16'h3, {14'h0, pend, ovr});
    s = sens;
    v = val;
    rd(ADDR_TEMP_RESULT, d);
    chk("overwritten word", exp_word(s, v, pins), d);
    chk("flags after read", 16'h0, {14'h0, pend, ovr});
    // Starved converter: remote 1 times out as a fault
    @(posedge mclk_i);
    en <= 3'h2;
    mute <= 1'b1;
    wait_evt();
    wait_evt();
    rd(ADDR_TEMP_RESULT, d);
    chk("timeout word", {10'h200, 2'h0, 2'h1, 1'b1, 1'b0}, d);
    tally_and_finish();
  end
endmodule
`default_nettype wire
